// ---- hw/dmb_pkg.sv ----
`default_nettype none
package dmb_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_PORT0 = 8'h00;
    localparam logic [7:0] ADDR_PTR0 = 8'h01;
    localparam logic [7:0] ADDR_PORT1 = 8'h02;
    localparam logic [7:0] ADDR_PTR1 = 8'h03;
    localparam logic [7:0] ADDR_BANK = 8'h04;
    localparam logic [7:0] ADDR_ACC = 8'h05;
    localparam logic [7:0] ADDR_EEC = 8'h40;
    localparam logic [7:0] ADDR_GP_BASE = 8'h80;
    // Field position and reset values
    localparam int BANK_BIT = 0;
    localparam logic BANK_RESET = 1'b0;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // ALU operations
    typedef enum logic [2:0] {
        DMB_ALU_PASS,
        DMB_ALU_ADD,
        DMB_ALU_SUB,
        DMB_ALU_AND,
        DMB_ALU_OR,
        DMB_ALU_XOR,
        DMB_ALU_INC,
        DMB_ALU_DEC
    } dmb_alu_op_t;
    // Destination of a result
    typedef enum logic {
        DMB_DST_ACC,
        DMB_DST_MEM
    } dmb_dst_t;
endpackage : dmb_pkg
`default_nettype wire

// ---- hw/dmb_mem_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// Physical memory port between decoder and storage
interface dmb_mem_if;
    logic we;
    logic bank;
    logic [6:0] index;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output bank, output index, output wdata, input rdata);
    modport store (input we, input bank, input index, input wdata, output rdata);
endinterface : dmb_mem_if
`default_nettype wire

// ---- hw/dmb_gp_ram.sv ----
`timescale 1ns/1ns
`default_nettype none
module dmb_gp_ram #(
    parameter int DEPTH = 128
) (
    input wire logic clk,
    dmb_mem_if.store mem
);
    // Two banks of general purpose storage, read combinationally
    logic [7:0] ram_r [2][DEPTH];

    always_ff @(posedge clk)
    begin
        if (mem.we)
        begin
            ram_r[mem.bank][mem.index] <= mem.wdata;
        end
    end

    assign mem.rdata = ram_r[mem.bank][mem.index];
endmodule : dmb_gp_ram
`default_nettype wire

// ---- hw/dmb_bank.sv ----
`timescale 1ns/1ns
`default_nettype none
module dmb_bank (
    input wire logic clk,
    input wire logic reset,
    input wire logic wdt_pd_reset,
    input wire logic op_valid,
    input wire dmb_pkg::dmb_alu_op_t op_alu,
    input wire dmb_pkg::dmb_dst_t op_dst,
    input wire logic op_use_mem,
    input wire logic [7:0] op_addr,
    input wire logic [7:0] op_imm,
    input wire logic [7:0] eec_rdata,
    output logic [7:0] rdata,
    output logic [7:0] acc,
    output logic bank_sel,
    output logic [7:0] eec_wdata,
    output logic eec_we
);
    typedef struct packed {
        logic [7:0] ptr0;
        logic [7:0] ptr1;
        logic bank;
        logic [7:0] acc;
        logic [7:0] rdata;
        logic [7:0] eec_wdata;
        logic eec_we;
    } dmb_state_t;

    dmb_state_t st_r;
    dmb_state_t st_nxt;
    dmb_mem_if mem ();
    logic [7:0] eff_addr;
    logic eff_bank;
    logic eff_null;
    logic [7:0] operand;
    logic [7:0] result;
    logic [7:0] src;

    dmb_gp_ram #(.DEPTH(128)) u_ram (.clk(clk), .mem(mem));

    function automatic logic is_port(input logic [7:0] a);
        return (a == dmb_pkg::ADDR_PORT0) || (a == dmb_pkg::ADDR_PORT1);
    endfunction : is_port

    ////////////////////////////////////////////////////////////////////////
    // Address resolution
    always_comb
    begin
        eff_addr = op_addr;
        eff_bank = 1'b0;
        eff_null = 1'b0;
        if (op_addr == dmb_pkg::ADDR_PORT0)
        begin
            eff_addr = st_r.ptr0;
            eff_bank = 1'b0;
        end
        else if (op_addr == dmb_pkg::ADDR_PORT1)
        begin
            eff_addr = st_r.ptr1;
            eff_bank = st_r.bank;
        end
        if (is_port(op_addr) && is_port(eff_addr))
        begin
            eff_null = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb
    begin
        src = dmb_pkg::ZERO_BYTE;
        if (eff_null)
        begin
            src = dmb_pkg::ZERO_BYTE;
        end
        else if (eff_addr >= dmb_pkg::ADDR_GP_BASE)
        begin
            src = mem.rdata;
        end
        else if (eff_bank)
        begin
            if (eff_addr == dmb_pkg::ADDR_EEC)
            begin
                src = eec_rdata;
            end
        end
        else
        begin
            case (eff_addr)
                dmb_pkg::ADDR_PTR0: src = st_r.ptr0;
                dmb_pkg::ADDR_PTR1: src = st_r.ptr1;
                dmb_pkg::ADDR_BANK: src = {7'h00, st_r.bank};
                dmb_pkg::ADDR_ACC: src = st_r.acc;
                default: src = dmb_pkg::ZERO_BYTE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ALU, accumulator centric
    always_comb
    begin
        operand = op_use_mem ? src : op_imm;
        case (op_alu)
            dmb_pkg::DMB_ALU_PASS: result = operand;
            dmb_pkg::DMB_ALU_ADD: result = 8'(st_r.acc + operand);
            dmb_pkg::DMB_ALU_SUB: result = 8'(st_r.acc - operand);
            dmb_pkg::DMB_ALU_AND: result = st_r.acc & operand;
            dmb_pkg::DMB_ALU_OR: result = st_r.acc | operand;
            dmb_pkg::DMB_ALU_XOR: result = st_r.acc ^ operand;
            dmb_pkg::DMB_ALU_INC: result = 8'(operand + 8'h01);
            dmb_pkg::DMB_ALU_DEC: result = 8'(operand - 8'h01);
            default: result = operand;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory port and next state
    logic mem_wr;
    always_comb
    begin
        mem_wr = op_valid && op_dst == dmb_pkg::DMB_DST_MEM && !eff_null;
        mem.we = mem_wr && eff_addr >= dmb_pkg::ADDR_GP_BASE;
        mem.bank = eff_bank;
        mem.index = eff_addr[6:0];
        // No direct move: memory writes only carry the ALU result
        mem.wdata = result;
        st_nxt = st_r;
        st_nxt.eec_we = 1'b0;
        st_nxt.rdata = src;
        if (op_valid && op_dst == dmb_pkg::DMB_DST_ACC)
        begin
            st_nxt.acc = result;
        end
        if (mem_wr && eff_addr < dmb_pkg::ADDR_GP_BASE)
        begin
            if (!eff_bank)
            begin
                case (eff_addr)
                    dmb_pkg::ADDR_PTR0: st_nxt.ptr0 = result;
                    dmb_pkg::ADDR_PTR1: st_nxt.ptr1 = result;
                    dmb_pkg::ADDR_BANK: st_nxt.bank = result[dmb_pkg::BANK_BIT];
                    dmb_pkg::ADDR_ACC: st_nxt.acc = result;
                    default: st_nxt = st_nxt;
                endcase
            end
            else if (eff_addr == dmb_pkg::ADDR_EEC)
            begin
                st_nxt.eec_we = 1'b1;
                st_nxt.eec_wdata = result;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_r.ptr0 <= dmb_pkg::PTR_RESET;
            st_r.ptr1 <= dmb_pkg::PTR_RESET;
            st_r.acc <= dmb_pkg::ACC_RESET;
            st_r.rdata <= dmb_pkg::ZERO_BYTE;
            st_r.eec_wdata <= dmb_pkg::ZERO_BYTE;
            st_r.eec_we <= 1'b0;
            // keep bank on watchdog power-down reset
            st_r.bank <= wdt_pd_reset ? st_r.bank : dmb_pkg::BANK_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign acc = st_r.acc;
    assign bank_sel = st_r.bank;
    assign eec_wdata = st_r.eec_wdata;
    assign eec_we = st_r.eec_we;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_unused_zero: assert property (@(posedge clk) disable iff (reset)
        op_valid && op_addr == 8'h10 |=> rdata == 8'h00)
        else $error("unused address read nonzero");
    a_port_self_zero: assert property (@(posedge clk) disable iff (reset)
        op_valid && op_addr == 8'h02 && st_r.ptr1 == 8'h00 |=> rdata == 8'h00)
        else $error("port via port read nonzero");
    a_ptr0_redirect: assert property (@(posedge clk) disable iff (reset)
        op_valid && op_addr == 8'h00 && st_r.ptr0 == 8'h01 |=> rdata == $past(st_r.ptr0))
        else $error("indirect read of pointer wrong");
    a_bank_upper_zero: assert property (@(posedge clk) disable iff (reset)
        op_valid && op_addr == 8'h04 |=> rdata[7:1] == 7'h00)
        else $error("bank upper bits nonzero");
    a_bank_write: assert property (@(posedge clk) disable iff (reset)
        op_valid && op_addr == 8'h04 && op_dst == dmb_pkg::DMB_DST_MEM
        |=> bank_sel == $past(result[0]))
        else $error("bank select not written");
    a_direct_bank0: assert property (@(posedge clk) disable iff (reset)
        op_valid && !is_port(op_addr) |-> !mem.bank)
        else $error("direct access left bank 0");
    a_ptr0_bank0: assert property (@(posedge clk) disable iff (reset)
        op_valid && op_addr == 8'h00 |-> !mem.bank ##1 !eec_we)
        else $error("pointer zero reached bank 1");
    a_acc_result: assert property (@(posedge clk) disable iff (reset)
        op_valid && op_dst == dmb_pkg::DMB_DST_ACC |=> acc == $past(result))
        else $error("acc missed result");
    a_ro_ignored: assert property (@(posedge clk) disable iff (reset)
        op_valid && op_addr == 8'h06 && op_dst == dmb_pkg::DMB_DST_MEM
        |=> $stable(st_r.ptr0) && $stable(st_r.ptr1) && $stable(bank_sel))
        else $error("protected write altered state");
    a_bank_reset: assert property (@(posedge clk)
        reset && !wdt_pd_reset |=> !bank_sel)
        else $error("bank not cleared by reset");
    c_bank1_access: cover property (@(posedge clk) disable iff (reset)
        op_valid && op_addr == 8'h02 && st_r.bank && st_r.ptr1 >= 8'h80);
    c_eec_write: cover property (@(posedge clk) disable iff (reset) eec_we);
    c_ptr_inc: cover property (@(posedge clk) disable iff (reset)
        op_valid && op_addr == 8'h01 && op_alu == dmb_pkg::DMB_ALU_INC);
endmodule : dmb_bank
`default_nettype wire

// ---- verification/dmb_eec_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module dmb_eec_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    ////////////////////////////////////////////////////////////
    // control register storage
    // Updates on the edge after the pulse, so a read must wait one op
    always_ff @(posedge clk)
    begin
        if (reset)
            rdata <= 8'h00;
        else if (we)
            rdata <= wdata;
    end
endmodule : dmb_eec_model
`default_nettype wire

// ---- verification/dmb_bank_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module dmb_bank_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wdt_pd_reset = 1'b0;
    logic op_valid = 1'b0;
    dmb_pkg::dmb_alu_op_t op_alu = dmb_pkg::DMB_ALU_PASS;
    dmb_pkg::dmb_dst_t op_dst = dmb_pkg::DMB_DST_ACC;
    logic op_use_mem = 1'b0;
    logic [7:0] op_addr = 8'h00;
    logic [7:0] op_imm = 8'h00;
    logic [7:0] eec_rdata, rdata, acc, eec_wdata;
    logic bank_sel, eec_we;
    int mismatches = 0;
    int checks_done = 0;

    always #25 clk = ~clk;

    dmb_bank DUT (
        .clk(clk), .reset(reset), .wdt_pd_reset(wdt_pd_reset), .op_valid(op_valid),
        .op_alu(op_alu), .op_dst(op_dst), .op_use_mem(op_use_mem), .op_addr(op_addr),
        .op_imm(op_imm), .eec_rdata(eec_rdata), .rdata(rdata), .acc(acc),
        .bank_sel(bank_sel), .eec_wdata(eec_wdata), .eec_we(eec_we)
    );
    dmb_eec_model eec_model (
        .clk(clk), .reset(reset), .we(eec_we), .wdata(eec_wdata), .rdata(eec_rdata)
    );

    ////////////////////////////////////////////////////////////
    // Valid stays high so ops run back to back; results are read after the edge
    task automatic op(input dmb_pkg::dmb_alu_op_t alu, input dmb_pkg::dmb_dst_t dst,
        input logic mem, input logic [7:0] addr, input logic [7:0] imm);
    begin
        op_alu = alu;
        op_dst = dst;
        op_use_mem = mem;
        op_addr = addr;
        op_imm = imm;
        op_valid = 1'b1;
        @(posedge clk);
        #1;
    end
    endtask : op

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        op(dmb_pkg::DMB_ALU_PASS, dmb_pkg::DMB_DST_MEM, 1'b0, a, v);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        op(dmb_pkg::DMB_ALU_PASS, dmb_pkg::DMB_DST_ACC, 1'b1, a, 8'h00);
    endtask : rd

    task automatic rst(input logic w);
    begin
        op_valid = 1'b0;
        wdt_pd_reset = w;
        reset = 1'b1;
        repeat (16) @(posedge clk);
        #1;
        reset = 1'b0;
        wdt_pd_reset = 1'b0;
    end
    endtask : rst

    task automatic t_indirect();
    begin
        wr(8'h01, 8'h80);
        wr(8'h00, 8'h5a);
        op(dmb_pkg::DMB_ALU_INC, dmb_pkg::DMB_DST_MEM, 1'b1, 8'h01, 8'h00);
        `CHK("ptr0 old", 8'h80, rdata)
        wr(8'h00, 8'ha5);
        rd(8'h80);
        `CHK("ram 80", 8'h5a, rdata)
        rd(8'h81);
        `CHK("ram 81", 8'ha5, rdata)
        rd(8'h01);
        `CHK("ptr0", 8'h81, rdata)
        wr(8'h01, 8'h01);
        rd(8'h00);
        `CHK("port0 ptr0", 8'h01, rdata)
        wr(8'h01, 8'h81);
    end
    endtask : t_indirect

    task automatic t_unused();
    begin
        wr(8'h10, 8'hff);
        rd(8'h10);
        `CHK("unused", 8'h00, rdata)
        wr(8'h04, 8'hff);
        rd(8'h04);
        `CHK("bank reg", 8'h01, rdata)
        `CHK("bank hi", 7'h00, rdata[7:1])
        `CHK("bank_sel", 1'b1, bank_sel)
        wr(8'h06, 8'hff);
        rd(8'h01);
        `CHK("ptr0 kept", 8'h81, rdata)
    end
    endtask : t_unused

    task automatic t_banks();
    begin
        wr(8'h03, 8'h80);
        wr(8'h02, 8'h33);
        rd(8'h80);
        `CHK("direct", 8'h5a, rdata)
        rd(8'h00);
        `CHK("port0 b1", 8'ha5, rdata)
        rd(8'h02);
        `CHK("port1 b1", 8'h33, rdata)
        wr(8'h04, 8'h00);
        rd(8'h02);
        `CHK("port1 b0", 8'h5a, rdata)
    end
    endtask : t_banks

    task automatic t_self();
    begin
        wr(8'h03, 8'h00);
        wr(8'h02, 8'h77);
        rd(8'h02);
        `CHK("port self", 8'h00, rdata)
        rd(8'h80);
        `CHK("ram kept", 8'h5a, rdata)
    end
    endtask : t_self

    task automatic t_eec();
    begin
        wr(8'h03, 8'h40);
        wr(8'h02, 8'h9c);
        `CHK("eec_we b0", 1'b0, eec_we)
        wr(8'h04, 8'h01);
        wr(8'h02, 8'h9c);
        `CHK("eec_we", 1'b1, eec_we)
        `CHK("eec_wdata", 8'h9c, eec_wdata)
        rd(8'h40);
        `CHK("eec direct", 8'h00, rdata)
        rd(8'h02);
        `CHK("eec read", 8'h9c, rdata)
    end
    endtask : t_eec

    task automatic t_alu();
        logic [7:0] exp [8] = '{8'h0f, 8'h4b, 8'h2d, 8'h0c, 8'h3f, 8'h33, 8'h10, 8'h0e};
    begin
        for (int i = 0; i < 8; i++)
        begin
            op(dmb_pkg::DMB_ALU_PASS, dmb_pkg::DMB_DST_ACC, 1'b0, 8'h00, 8'h3c);
            op(dmb_pkg::dmb_alu_op_t'(i[2:0]), dmb_pkg::DMB_DST_ACC, 1'b0, 8'h00, 8'h0f);
            `CHK("acc alu", exp[i], acc)
        end
    end
    endtask : t_alu

    ////////////////////////////////////////////////////////////
    task automatic end_of_test();
    begin
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask : end_of_test

    initial
    begin
        rst(1'b0);
        `CHK("bank rst", 1'b0, bank_sel)
        t_indirect();
        t_unused();
        t_banks();
        t_self();
        t_eec();
        rst(1'b1);
        `CHK("bank kept", 1'b1, bank_sel)
        rst(1'b0);
        `CHK("bank clr", 1'b0, bank_sel)
        t_alu();
        end_of_test();
    end

    // Hang guard, far above the roughly one hundred cycles the run needs
    initial
    begin
        #1000000;
        mismatches++;
        end_of_test();
    end
endmodule : dmb_bank_test
`default_nettype wire
